//--- src/irb_register_bank.sv
`timescale 1ns/1ps
// Operation
// R1: An 8-bit pointer picks the register that answers the next bus access.
// R2: The first data byte of every write loads the pointer.
// R3: The host sets the pointer by a write before reading another register.
// R4: After reset the pointer is zero, selecting the thermopile voltage.
// R5: Pointer 0 is voltage, 1 is ambient temperature, 2 is configuration.
// R6: Pointers FE and FF are read-only maker and part codes.
// R7: The voltage result is 16-bit twos complement at 156.25 nV per count.
// R8: Positive full scale reads 7FFF and negative full scale reads 8000.
// R9: Voltage beyond full scale saturates at those codes, never wraps.
// R10: Writes to the voltage and temperature registers change nothing.
// R11: The 14-bit temperature updates only when a conversion finishes.
// R12: After power-up or software reset the temperature reads zero.
// R13: Temperature sits signed in bits 15:2 with bits 1:0 reading zero.
// R14: The pointer is write-only; reads return the selected register.
// R15: Writing the software reset bit resets all registers at once.
// R16: Ready sets on new results and clears on result read or config write.
// R17: Sixteen-bit registers move as two bytes, high byte first.
module irb_register_bank #(
    parameter logic [15:0] MAKER_CODE = 16'h0a5c, // Arbitrary value
    parameter logic [15:0] PART_CODE = 16'h0123 // Arbitrary value
) (
    input wire logic mclk,
    input wire logic reset_n,
    input irb_pkg::irb_bus_t bus,
    input irb_pkg::irb_conv_t conv,
    output logic [irb_pkg::BYTE_W-1:0] rd_data,
    output logic [irb_pkg::OPSEL_W-1:0] operating_select,
    output logic [irb_pkg::RATE_W-1:0] sample_rate_select,
    output logic result_ready_flag,
    output logic ready_pin_o,
    output logic ready_pin_oe
);
    import irb_pkg::*;

    // ************************************************************
    // State
    // ************************************************************
    logic [PTR_W-1:0] ptr_r;
    logic [PTR_W-1:0] ptr_nxt;
    logic [IDX_W-1:0] idx_r;
    logic [IDX_W-1:0] idx_nxt;
    logic [BYTE_W-1:0] hi_r;
    logic [BYTE_W-1:0] hi_nxt;
    logic [BYTE_W-1:0] rd_r;
    logic [BYTE_W-1:0] rd_nxt;
    logic [BYTE_W-1:0] lo_r;
    logic [BYTE_W-1:0] lo_nxt;
    logic [DATA_W-1:0] volt_r;
    logic [DATA_W-1:0] volt_nxt;
    logic [TEMP_W-1:0] temp_r;
    logic [TEMP_W-1:0] temp_nxt;
    logic [OPSEL_W-1:0] opsel_r;
    logic [OPSEL_W-1:0] opsel_nxt;
    logic [RATE_W-1:0] rate_r;
    logic [RATE_W-1:0] rate_nxt;
    logic en_r;
    logic en_nxt;
    logic rdy_r;
    logic rdy_nxt;

    // ************************************************************
    // Shared decode
    // ************************************************************
    logic [DATA_W-1:0] sel_word;
    logic [DATA_W-1:0] cfg_word;
    logic [DATA_W-1:0] volt_sat;
    logic [DATA_W-1:0] wr_word;
    logic raw_fits;
    logic cfg_commit;
    logic sw_reset;
    logic result_read;
    logic conv_take;

    // Only the third byte commits, so a cut write never half-lands
    always_comb begin
        cfg_commit = bus.wr_stb && idx_r == IDX_LO
            && ptr_r == PTR_CFG;   // see R10
        sw_reset = cfg_commit && wr_word[CFG_RST_BIT];   // see R15
        result_read = bus.start && bus.read
            && (ptr_r == PTR_VOLT || ptr_r == PTR_TEMP);   // see R16
        // Power-down drops results, so stale conversions never land
        conv_take = conv.done && opsel_r != OPSEL_OFF;
    end

    // ************************************************************
    // Read view
    // ************************************************************
    // The reset bit self-clears, so it always reads back as zero
    always_comb begin
        cfg_word = RESULT_RESET;
        cfg_word[CFG_OPSEL_LO +: OPSEL_W] = opsel_r;
        cfg_word[CFG_RATE_LO +: RATE_W] = rate_r;
        cfg_word[CFG_EN_BIT] = en_r;
        cfg_word[CFG_RDY_BIT] = rdy_r;
    end

    // The pointer itself is never a read source
    always_comb begin
        unique case (ptr_r)   // see R5, see R6, see R14
            PTR_VOLT: sel_word = volt_r;
            PTR_TEMP: sel_word = {temp_r, TEMP_PAD};   // see R13
            PTR_CFG: sel_word = cfg_word;
            PTR_MAKER: sel_word = MAKER_CODE;
            PTR_PART: sel_word = PART_CODE;
            default: sel_word = RESULT_RESET;
        endcase
    end

    // ************************************************************
    // Voltage clipping
    // ************************************************************
    // The raw value fits when the result's sign bit and all bits above it agree
    always_comb begin
        raw_fits = (&conv.volt_raw[RAW_W-1:DATA_W-1])
            | ~(|conv.volt_raw[RAW_W-1:DATA_W-1]);
        if (raw_fits) begin
            volt_sat = conv.volt_raw[DATA_W-1:0];   // see R7
        end else if (conv.volt_raw[RAW_W-1]) begin
            volt_sat = VOLT_MIN;   // see R8, see R9
        end else begin
            volt_sat = VOLT_MAX;   // see R8, see R9
        end
    end

    assign wr_word = {hi_r, bus.wr_data};   // see R17

    // ************************************************************
    // Pointer and byte counter
    // ************************************************************
    // Bytes past the third are counted out and ignored
    always_comb begin
        ptr_nxt = ptr_r;
        idx_nxt = idx_r;
        if (bus.start) begin
            idx_nxt = IDX_PTR;
        end
        if (bus.wr_stb) begin
            if (idx_r == IDX_PTR) begin
                ptr_nxt = bus.wr_data;   // see R1, see R2
            end
            if (idx_r != IDX_DONE) begin
                idx_nxt = idx_r + 2'h1;
            end
        end
        if (sw_reset) begin
            ptr_nxt = PTR_RESET;   // see R15
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            ptr_r <= PTR_RESET;   // see R4
            idx_r <= IDX_PTR;
        end else begin
            ptr_r <= ptr_nxt;
            idx_r <= idx_nxt;
        end
    end

    // ************************************************************
    // Write staging
    // ************************************************************
    always_comb begin
        hi_nxt = hi_r;
        if (bus.wr_stb && idx_r == IDX_HI) begin
            hi_nxt = bus.wr_data;   // see R17
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            hi_r <= BYTE_ZERO;
        end else begin
            hi_r <= hi_nxt;
        end
    end

    // ************************************************************
    // Read bytes
    // ************************************************************
    // A read snapshots the whole word so both bytes belong together
    always_comb begin
        rd_nxt = rd_r;
        lo_nxt = lo_r;
        if (bus.start && bus.read) begin
            rd_nxt = sel_word[DATA_W-1 -: BYTE_W];   // see R17
            lo_nxt = sel_word[BYTE_W-1:0];
        end
        if (bus.rd_stb) begin
            rd_nxt = lo_r;   // see R17
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rd_r <= BYTE_ZERO;
            lo_r <= BYTE_ZERO;
        end else begin
            rd_r <= rd_nxt;
            lo_r <= lo_nxt;
        end
    end

    // ************************************************************
    // Results
    // ************************************************************
    // Host writes reach these only through software reset, otherwise only finished conversions
    always_comb begin
        volt_nxt = volt_r;
        temp_nxt = temp_r;
        if (conv_take) begin
            volt_nxt = volt_sat;   // see R9
            temp_nxt = conv.temp;   // see R11
        end
        if (sw_reset) begin
            volt_nxt = RESULT_RESET;   // see R15
            temp_nxt = RESULT_RESET[TEMP_W-1:0];   // see R12
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            volt_r <= RESULT_RESET;
            temp_r <= RESULT_RESET[TEMP_W-1:0];   // see R12
        end else begin
            volt_r <= volt_nxt;
            temp_r <= temp_nxt;
        end
    end

    // ************************************************************
    // Configuration
    // ************************************************************
    // Reset wins over a field write in the same cycle
    always_comb begin
        opsel_nxt = opsel_r;
        rate_nxt = rate_r;
        en_nxt = en_r;
        if (cfg_commit) begin
            opsel_nxt = wr_word[CFG_OPSEL_LO +: OPSEL_W];
            rate_nxt = wr_word[CFG_RATE_LO +: RATE_W];
            en_nxt = wr_word[CFG_EN_BIT];
        end
        if (sw_reset) begin
            opsel_nxt = OPSEL_RESET;   // see R15
            rate_nxt = RATE_RESET;
            en_nxt = EN_RESET;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            opsel_r <= OPSEL_RESET;
            rate_r <= RATE_RESET;
            en_r <= EN_RESET;
        end else begin
            opsel_r <= opsel_nxt;
            rate_r <= rate_nxt;
            en_r <= en_nxt;
        end
    end

    // ************************************************************
    // Ready flag
    // ************************************************************
    // A new result beats a read or config-write clear in the same cycle; software reset still wins over it
    always_comb begin
        rdy_nxt = rdy_r;
        if (result_read || cfg_commit) begin
            rdy_nxt = 1'h0;   // see R16
        end
        if (conv_take) begin
            rdy_nxt = 1'h1;   // see R16
        end
        if (sw_reset) begin
            rdy_nxt = 1'h0;   // see R15
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdy_r <= 1'h0;
        end else begin
            rdy_r <= rdy_nxt;
        end
    end

    // ************************************************************
    // Outputs
    // ************************************************************
    assign rd_data = rd_r;
    assign operating_select = opsel_r;
    assign sample_rate_select = rate_r;
    assign result_ready_flag = rdy_r;
    // Open-drain ready pin only ever pulls low
    assign ready_pin_o = 1'h0;
    assign ready_pin_oe = en_r & rdy_r;

endmodule

//--- src/irb_pkg.sv
package irb_pkg;

    // ************************************************************
    // Widths
    // ************************************************************
    localparam int PTR_W = 8;
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;
    localparam int RAW_W = 20;
    localparam int TEMP_W = 14;
    localparam int OPSEL_W = 3;
    localparam int RATE_W = 3;
    localparam int IDX_W = 2;

    // ************************************************************
    // Pointer codes
    // ************************************************************
    localparam logic [PTR_W-1:0] PTR_VOLT = 8'h00;
    localparam logic [PTR_W-1:0] PTR_TEMP = 8'h01;
    localparam logic [PTR_W-1:0] PTR_CFG = 8'h02;
    localparam logic [PTR_W-1:0] PTR_MAKER = 8'hfe;
    localparam logic [PTR_W-1:0] PTR_PART = 8'hff;
    localparam logic [PTR_W-1:0] PTR_RESET = 8'h00;

    // ************************************************************
    // Configuration field layout and reset values
    // ************************************************************
    localparam int CFG_RST_BIT = 15;
    localparam int CFG_OPSEL_LO = 12;
    localparam int CFG_RATE_LO = 9;
    localparam int CFG_EN_BIT = 8;
    localparam int CFG_RDY_BIT = 7;
    localparam logic [OPSEL_W-1:0] OPSEL_RESET = 3'h7;
    localparam logic [OPSEL_W-1:0] OPSEL_OFF = 3'h0;
    localparam logic [RATE_W-1:0] RATE_RESET = 3'h2;
    localparam logic EN_RESET = 1'h0;

    // ************************************************************
    // Result codes, byte reset value and byte counter indices
    // ************************************************************
    localparam logic [DATA_W-1:0] VOLT_MAX = 16'h7fff;
    localparam logic [DATA_W-1:0] VOLT_MIN = 16'h8000;
    localparam logic [DATA_W-1:0] RESULT_RESET = 16'h0000;
    localparam logic [1:0] TEMP_PAD = 2'h0;
    localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;
    localparam logic [IDX_W-1:0] IDX_PTR = 2'h0;
    localparam logic [IDX_W-1:0] IDX_HI = 2'h1;
    localparam logic [IDX_W-1:0] IDX_LO = 2'h2;
    localparam logic [IDX_W-1:0] IDX_DONE = 2'h3;

    // Byte-level requests from the serial front end
    typedef struct packed {
        logic start;
        logic read;
        logic wr_stb;
        logic [BYTE_W-1:0] wr_data;
        logic rd_stb;
    } irb_bus_t;

    // Finished conversion from the measurement sequencer
    typedef struct packed {
        logic done;
        logic signed [RAW_W-1:0] volt_raw;
        logic [TEMP_W-1:0] temp;
    } irb_conv_t;

endpackage

//--- tb/irb_checker_sva.sv
`timescale 1ns/1ps
module irb_checker_sva (
    input wire logic mclk,
    input wire logic reset_n,
    input irb_pkg::irb_bus_t bus,
    input irb_pkg::irb_conv_t conv,
    input wire logic [irb_pkg::BYTE_W-1:0] rd_data,
    input wire logic [irb_pkg::OPSEL_W-1:0] operating_select,
    input wire logic [irb_pkg::RATE_W-1:0] sample_rate_select,
    input wire logic result_ready_flag,
    input wire logic ready_pin_o,
    input wire logic ready_pin_oe
);
    import irb_pkg::*;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    property p_set; conv.done && operating_select != OPSEL_OFF
        |=> result_ready_flag; endproperty
    a_set: assert property (p_set) else $error("flag not set");
    property p_off; conv.done && operating_select == OPSEL_OFF
        |=> !$rose(result_ready_flag); endproperty
    a_off: assert property (p_off) else $error("flag set when off");
    property p_fall; $fell(result_ready_flag)
        |-> $past(bus.wr_stb || (bus.start && bus.read)); endproperty
    a_fall: assert property (p_fall) else $error("flag lost");
    property p_oe; ready_pin_oe |-> result_ready_flag; endproperty
    a_oe: assert property (p_oe) else $error("pin without flag");
    property p_pin; ready_pin_o == 1'b0; endproperty
    a_pin: assert property (p_pin) else $error("pin level high");
    property p_mod; $changed(operating_select) |-> $past(bus.wr_stb);
    endproperty
    a_mod: assert property (p_mod) else $error("mode moved");
    property p_rate; $changed(sample_rate_select) |-> $past(bus.wr_stb);
    endproperty
    a_rate: assert property (p_rate) else $error("rate moved");
    property p_rd; $changed(rd_data)
        |-> $past(bus.rd_stb || (bus.start && bus.read)); endproperty
    a_rd: assert property (p_rd) else $error("read byte moved");
    c_read: cover property (bus.start && bus.read ##2 bus.rd_stb);
    c_conv: cover property (conv.done ##1 result_ready_flag);
    c_cfg: cover property (bus.wr_stb ##1 $changed(operating_select));
endmodule
bind irb_register_bank irb_checker_sva irb_checker_sva_i (.mclk(mclk),
    .reset_n(reset_n), .bus(bus), .conv(conv), .rd_data(rd_data),
    .operating_select(operating_select),
    .sample_rate_select(sample_rate_select),
    .result_ready_flag(result_ready_flag), .ready_pin_o(ready_pin_o),
    .ready_pin_oe(ready_pin_oe));

//--- tb/irb_host_model.sv
`timescale 1ns/1ps
module irb_host_model (
    input wire logic mclk,
    input wire logic [irb_pkg::BYTE_W-1:0] rd_data,
    output irb_pkg::irb_bus_t bus
);
    import irb_pkg::*;
    initial bus = '0;
    // Released data flips so a stale byte never looks valid
    task automatic pulse(input logic [3:0] c, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{c[3], c[2], c[1], c[1] ? d : ~bus.wr_data, c[0]};
    endtask
    task automatic xfer_write(input logic [31:0] w, input int n);
        pulse(4'b1000, 8'h00);
        for (int i = 0; i < n; i++) begin
            pulse(4'b0010, w[31-8*i -: 8]);
        end
        pulse(4'b0000, 8'h00);
    endtask
    task automatic xfer_read(input int gap, output logic [15:0] v);
        pulse(4'b1100, 8'h00);
        repeat (gap + 1) pulse(4'b0000, 8'h00);
        pulse(4'b0001, 8'h00);
        v[15:8] = rd_data;
        pulse(4'b0000, 8'h00);
        @(posedge mclk);
        v[7:0] = rd_data;
    endtask
endmodule

//--- tb/irb_register_bank_test.sv
`timescale 1ns/1ps
module irb_register_bank_test;
    import irb_pkg::*;
    localparam logic [15:0] MAKER = 16'h1357; // Arbitrary value
    localparam logic [15:0] PART = 16'h2468; // Arbitrary value
    logic mclk;
    logic reset_n;
    irb_bus_t bus;
    irb_conv_t conv;
    logic [BYTE_W-1:0] rd_data;
    logic [OPSEL_W-1:0] operating_select;
    logic [RATE_W-1:0] sample_rate_select;
    logic result_ready_flag, ready_pin_o, ready_pin_oe;
    int mismatches = 0;
    int checks_done = 0;
    logic [15:0] got;
    logic [19:0] raws [6] = '{20'h0_7fff, 20'h0_8000, 20'hf_8000,
        20'hf_7fff, 20'h0_0001, 20'hf_ffff};
    logic [15:0] vexp [6] = '{16'h7fff, 16'h7fff, 16'h8000, 16'h8000,
        16'h0001, 16'hffff};
    irb_register_bank #(.MAKER_CODE(MAKER), .PART_CODE(PART))
        irb_register_bank_i (.mclk(mclk), .reset_n(reset_n), .bus(bus),
        .conv(conv), .rd_data(rd_data), .operating_select(operating_select),
        .sample_rate_select(sample_rate_select),
        .result_ready_flag(result_ready_flag), .ready_pin_o(ready_pin_o),
        .ready_pin_oe(ready_pin_oe));
    irb_host_model irb_host_model_i (.mclk(mclk), .rd_data(rd_data),
        .bus(bus));
    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic wr(input logic [31:0] w, input int n);
        irb_host_model_i.xfer_write(w, n);
        @(negedge mclk);
    endtask
    task automatic rd(input logic [7:0] p, input logic [15:0] exp);
        wr({p, 24'h0}, 1);
        irb_host_model_i.xfer_read(0, got);
        check("register", got, exp);
    endtask
    task automatic cv(input logic [19:0] raw, input logic [13:0] t);
        @(posedge mclk);
        conv <= '{1'b1, raw, t};
        @(posedge mclk);
        conv.done <= 1'b0;
        @(negedge mclk);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    initial begin
        repeat (5000) @(posedge mclk);
        mismatches++;
        conclude();
    end
    initial begin
        reset_n = 1'b0;
        conv = '0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        irb_host_model_i.xfer_read(2, got);
        check("reset read", got, RESULT_RESET);
        rd(PTR_CFG, 16'h7400);
        rd(PTR_TEMP, RESULT_RESET);
        rd(PTR_MAKER, MAKER);
        rd(PTR_PART, PART);
        rd(8'h03, 16'h0000);
        for (int i = 0; i < 6; i++) begin
            cv(raws[i], raws[i][13:0]);
            check("flag", {15'h0, result_ready_flag}, 16'h0001);
            rd(PTR_VOLT, vexp[i]);
            check("flag", {15'h0, result_ready_flag}, 16'h0000);
            rd(PTR_TEMP, {raws[i][13:0], TEMP_PAD});
        end
        wr({PTR_VOLT, 16'h1234, 8'h00}, 3);
        irb_host_model_i.xfer_read(0, got);
        check("ro volt", got, 16'hffff);
        wr({PTR_CFG, 16'h7300, 8'hff}, 4);
        check("rate", {13'h0, sample_rate_select}, 16'h0001);
        cv(20'h0_0123, 14'h0123);
        check("oe", {15'h0, ready_pin_oe}, 16'h0001);
        check("pin", {15'h0, ready_pin_o}, 16'h0000);
        wr({PTR_CFG, 16'h0000, 8'h00}, 2);
        check("mode", {13'h0, operating_select}, 16'h0007);
        wr({PTR_CFG, 16'h0300, 8'h00}, 3);
        check("flag", {15'h0, result_ready_flag}, 16'h0000);
        cv(20'h0_0456, 14'h0456);
        rd(PTR_TEMP, 16'h048c);
        wr({PTR_CFG, 16'h8000, 8'h00}, 3);
        check("rate", {13'h0, sample_rate_select}, 16'h0002);
        irb_host_model_i.xfer_read(0, got);
        check("sw reset", got, RESULT_RESET);
        rd(PTR_TEMP, RESULT_RESET);
        rd(PTR_CFG, 16'h7400);
        conclude();
    end
endmodule
